// >>> rtl/adc_pin_mux_pkg.sv
// Shared widths, bit positions and reset values for the output pin mux
package adc_pin_mux_pkg;
  localparam int unsigned RESULT_W  = 14;
  localparam int unsigned BUS_W     = 16;
  localparam int unsigned HALF_W    = 7;
  localparam int unsigned OS_W      = 3;
  localparam int unsigned SIGN_BIT  = 13;
  localparam int unsigned EXT_W     = BUS_W - RESULT_W;
  localparam int unsigned BIT7_POS  = 7;
  localparam int unsigned BIT8_POS  = 8;
  localparam int unsigned UPPER_LSB = 9;
  localparam logic [BUS_W-1:0]  WORD_RESET = 16'h0000;
  localparam logic [OS_W-1:0]   OS_RESET   = 3'h0;
  localparam logic [HALF_W-1:0] HALF_ZERO  = 7'h00;
endpackage : adc_pin_mux_pkg

// >>> rtl/serial_shifter.sv
// Two-lane serial shift register behind the shared serial output pins
`timescale 1ns/1ps
module serial_shifter (
  input  wire logic                                 core_clk,
  input  wire logic                                 reset_n,
  input  wire logic                                 clkEn,
  input  wire logic                                 loadWord,
  input  wire logic                                 shiftBit,
  input  wire logic [adc_pin_mux_pkg::BUS_W-1:0]    wordA,
  input  wire logic [adc_pin_mux_pkg::BUS_W-1:0]    wordB,
  output logic                                      serialA,
  output logic                                      serialB
);
  logic [adc_pin_mux_pkg::BUS_W-1:0] shA_q;
  logic [adc_pin_mux_pkg::BUS_W-1:0] shB_q;

  // Load puts the MSB out first; each shift moves the next bit up
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      shA_q <= adc_pin_mux_pkg::WORD_RESET;
      shB_q <= adc_pin_mux_pkg::WORD_RESET;
    end else if (clkEn) begin
      if (loadWord) begin
        shA_q <= wordA;
        shB_q <= wordB;
      end else if (shiftBit) begin
        shA_q <= {shA_q[adc_pin_mux_pkg::BUS_W-2:0], 1'b0};
        shB_q <= {shB_q[adc_pin_mux_pkg::BUS_W-2:0], 1'b0};
      end
    end
  end

  assign serialA = shA_q[adc_pin_mux_pkg::BUS_W-1];
  assign serialB = shB_q[adc_pin_mux_pkg::BUS_W-1];

  // A shift without a load must bring the next bit up to both pins
  chk_shift_moves: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    clkEn && shiftBit && !loadWord
      |=> serialA == $past(shA_q[adc_pin_mux_pkg::BUS_W-2])
        && serialB == $past(shB_q[adc_pin_mux_pkg::BUS_W-2]))
    else $error("serial shift did not advance");
endmodule : serial_shifter

// >>> rtl/adc_output_pin_mux.sv
// Output data pin mux: three-state parallel bus or two serial outputs
`timescale 1ns/1ps
module adc_output_pin_mux (
  input  wire logic                                    core_clk,
  input  wire logic                                    reset_n,
  input  wire logic                                    clkEn,
  input  wire logic                                    interface_select,
  input  wire logic                                    chipSelect_n,
  input  wire logic                                    readOrSclk_n,
  input  wire logic [adc_pin_mux_pkg::OS_W-1:0]        oversample_ratio_sel,
  output logic      [adc_pin_mux_pkg::OS_W-1:0]        oversampleRatio,
  input  wire logic                                    resultLoad,
  input  wire logic [adc_pin_mux_pkg::RESULT_W-1:0]    resultA,
  input  wire logic [adc_pin_mux_pkg::RESULT_W-1:0]    resultB,
  output logic      [adc_pin_mux_pkg::HALF_W-1:0]      par_bus_upper,
  output logic                                         parBusUpperOe,
  output logic      [adc_pin_mux_pkg::HALF_W-1:0]      par_bus_lower,
  output logic                                         parBusLowerOe,
  output logic                                         bit7_or_serial_out_a,
  output logic                                         bit7Oe,
  output logic                                         bit8_or_serial_out_b,
  output logic                                         bit8Oe
);
  logic [adc_pin_mux_pkg::OS_W-1:0]  ratio_q;
  logic [adc_pin_mux_pkg::BUS_W-1:0] wordA_q;
  logic [adc_pin_mux_pkg::BUS_W-1:0] wordB_q;
  logic                              csPrev_q;
  logic                              sclkPrev_q;
  logic                              parRead;
  logic                              serFrame;
  logic                              csFall;
  logic                              sclkRise;
  logic                              serA;
  logic                              serB;

  // Overview: one held word per lane; word A feeds both pin modes, word B serial only. Parallel mode
  // drives the held A word onto all sixteen lines only during a read;
  // serial mode loads both words into the shifter on the chip-select
  // fall and steps them out on each sampled serial clock rise.
  // Limitation: strobes are sampled, so each serial clock level must
  // last at least one core clock; faster host clocks lose bits.

  // Bit positions used by the checks below, named once here
  localparam int unsigned TOP_POS  = adc_pin_mux_pkg::BUS_W - 1;
  localparam int unsigned SIGN_POS = adc_pin_mux_pkg::SIGN_BIT;
  localparam int unsigned B7_POS   = adc_pin_mux_pkg::BIT7_POS;
  localparam int unsigned B8_POS   = adc_pin_mux_pkg::BIT8_POS;
  localparam int unsigned LOW_TOP  = adc_pin_mux_pkg::HALF_W - 1;
  localparam int unsigned EXT_TOP  = adc_pin_mux_pkg::HALF_W - 1;
  localparam int unsigned EXT_MID  = EXT_TOP - 1;
  localparam int unsigned EXT_SIGN = SIGN_POS - adc_pin_mux_pkg::UPPER_LSB;

  // Ratio code held as a plain three-bit field, MSB first
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ratio_q <= adc_pin_mux_pkg::OS_RESET;
    end else if (clkEn) begin
      ratio_q <= oversample_ratio_sel;
    end
  end
  assign oversampleRatio = ratio_q;

  // Results arrive two's complement; widening copies the sign bit up
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wordA_q <= adc_pin_mux_pkg::WORD_RESET;
      wordB_q <= adc_pin_mux_pkg::WORD_RESET;
    end else if (clkEn && resultLoad) begin
      wordA_q <= {{adc_pin_mux_pkg::EXT_W{resultA[adc_pin_mux_pkg::SIGN_BIT]}},
                  resultA};
      wordB_q <= {{adc_pin_mux_pkg::EXT_W{resultB[adc_pin_mux_pkg::SIGN_BIT]}},
                  resultB};
    end
  end

  // Edge history of the host strobes; inputs are already synchronous
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      csPrev_q   <= 1'b1;
      sclkPrev_q <= 1'b1;
    end else if (clkEn) begin
      csPrev_q   <= chipSelect_n;
      sclkPrev_q <= readOrSclk_n;
    end
  end

  // Frame and edge decode; a load on the chip-select fall beats a shift
  assign parRead  = !interface_select && !chipSelect_n && !readOrSclk_n;
  assign serFrame = interface_select && !chipSelect_n;
  assign csFall   = interface_select && csPrev_q && !chipSelect_n;
  assign sclkRise = serFrame && !sclkPrev_q && readOrSclk_n;

  serial_shifter u_shifter (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .clkEn    (clkEn),
    .loadWord (csFall),
    .shiftBit (sclkRise),
    .wordA    (wordA_q),
    .wordB    (wordB_q),
    .serialA  (serA),
    .serialB  (serB)
  );

  // Parallel data comes straight from the held word; parallel lines unused
  // in serial mode are released, the board grounds them
  assign par_bus_upper = interface_select ? adc_pin_mux_pkg::HALF_ZERO
    : wordA_q[adc_pin_mux_pkg::BUS_W-1:adc_pin_mux_pkg::UPPER_LSB];
  assign par_bus_lower = interface_select ? adc_pin_mux_pkg::HALF_ZERO
    : wordA_q[adc_pin_mux_pkg::HALF_W-1:0];
  assign bit7_or_serial_out_a = interface_select ? serA
    : wordA_q[adc_pin_mux_pkg::BIT7_POS];
  assign bit8_or_serial_out_b = interface_select ? serB
    : wordA_q[adc_pin_mux_pkg::BIT8_POS];

  // Enables: parallel lines only during a read, else released for sharing
  assign parBusUpperOe = parRead;
  // Released lower lines in serial mode rely on the board grounding them;
  // driving zeros there would fight that tie, so the enable stays low
  assign parBusLowerOe = parRead;
  assign bit7Oe        = parRead || serFrame;
  assign bit8Oe        = parRead || serFrame;

  // Ratio code follows its pins one enabled cycle later
  chk_ratio_follow: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    clkEn |=> oversampleRatio == $past(oversample_ratio_sel))
    else $error("ratio select not followed");

  // A frozen clock enable must hold the ratio code as well
  chk_ratio_freeze: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    !clkEn |=> $stable(oversampleRatio))
    else $error("ratio changed while frozen");

  // Top two parallel lines always mirror the sign line
  chk_sign_copies: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    !interface_select |-> par_bus_upper[EXT_TOP] == par_bus_upper[EXT_SIGN]
      && par_bus_upper[EXT_MID] == par_bus_upper[EXT_SIGN])
    else $error("upper lines not sign extended");

  // A fresh result lands on the upper lines with its sign copied up;
  // the mode must stay parallel for the lines to show the word at all
  chk_result_sign: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    clkEn && resultLoad && !interface_select ##1 !interface_select
      |-> par_bus_upper[EXT_TOP] == $past(resultA[SIGN_POS])
        && par_bus_upper[EXT_SIGN:0]
          == $past(resultA[SIGN_POS:adc_pin_mux_pkg::UPPER_LSB]))
    else $error("loaded result not on upper lines");

  // The rest of the word lands on the lower lines and the shared pins
  chk_lower_bits: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    clkEn && resultLoad && !interface_select ##1 !interface_select
      |-> par_bus_lower == $past(resultA[LOW_TOP:0])
        && bit7_or_serial_out_a == $past(resultA[B7_POS])
        && bit8_or_serial_out_b == $past(resultA[B8_POS]))
    else $error("loaded result not on lower lines");

  // Held word stays put while the clock enable is low
  chk_word_freeze: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    !clkEn && !interface_select ##1 !interface_select
      |-> $stable(par_bus_upper) && $stable(par_bus_lower))
    else $error("held word changed while frozen");

  // Both strobes low in parallel mode opens every data line
  chk_par_drive: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    !interface_select && !chipSelect_n && !readOrSclk_n
      |-> parBusUpperOe && parBusLowerOe && bit7Oe && bit8Oe)
    else $error("parallel read not driven");

  // Shared pins carry result bits 7 and 8 during a read
  chk_shared_bits: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    parRead |-> bit7_or_serial_out_a == wordA_q[B7_POS]
      && bit8_or_serial_out_b == wordA_q[B8_POS])
    else $error("shared pins carry wrong bits");

  // Either strobe high leaves the bus free for other agents
  chk_par_release: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    !interface_select && (chipSelect_n || readOrSclk_n)
      |-> !parBusUpperOe && !parBusLowerOe && !bit7Oe && !bit8Oe)
    else $error("bus driven outside a read");

  // Shared pins are released whenever neither a read nor a frame runs
  chk_idle_release: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    !parRead && !serFrame |-> !bit7Oe && !bit8Oe)
    else $error("shared pins driven while idle");

  // Serial mode drives only the two shared pins, and only in a frame
  chk_serial_pins: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    interface_select |-> !parBusUpperOe && !parBusLowerOe
      && bit7Oe == !chipSelect_n && bit8Oe == !chipSelect_n)
    else $error("serial mode pin enables wrong");

  // Unused parallel values sit at zero so a grounded line never differs
  chk_serial_zero: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    interface_select |-> par_bus_upper == adc_pin_mux_pkg::HALF_ZERO
      && par_bus_lower == adc_pin_mux_pkg::HALF_ZERO)
    else $error("unused lines not at zero");

  // The chip-select fall puts both sign bits on the pins next cycle
  chk_serial_msb: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    clkEn && csFall |=> bit7_or_serial_out_a == $past(wordA_q[TOP_POS])
      && bit8_or_serial_out_b == $past(wordB_q[TOP_POS]))
    else $error("MSB not presented after frame start");

  // A frozen shifter keeps its current bit on the serial pins
  chk_serial_hold: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    interface_select && !clkEn ##1 interface_select
      |-> $stable(bit7_or_serial_out_a) && $stable(bit8_or_serial_out_b))
    else $error("serial bit moved while frozen");
endmodule : adc_output_pin_mux

// >>> verification/host_model.sv
// Host controller model that drives the read and frame strobes
`timescale 1ns/1ps
module host_model (
  input  wire logic core_clk,
  output logic      interface_select,
  output logic      chipSelect_n,
  output logic      readOrSclk_n
);
  // Idle in parallel mode and deselected
  initial begin
    interface_select = 1'b0;
    chipSelect_n     = 1'b1;
    readOrSclk_n     = 1'b1;
  end
  // Strobes move just after an edge and hold until the next call
  task automatic drive(input logic sel, input logic cs, input logic rd);
    @(posedge core_clk);
    interface_select <= sel;
    chipSelect_n     <= cs;
    readOrSclk_n     <= rd;
  endtask : drive
endmodule : host_model

// >>> verification/tb.sv
// Self-checking bench for the output pin mux
`timescale 1ns/1ps
module tb;
  logic        core_clk, reset_n, clkEn, resultLoad;
  logic        interface_select, chipSelect_n, readOrSclk_n;
  logic [2:0]  oversample_ratio_sel, oversampleRatio;
  logic [13:0] resultA, resultB;
  logic [6:0]  par_bus_upper, par_bus_lower;
  logic        parBusUpperOe, parBusLowerOe, bit7Oe, bit8Oe;
  logic        bit7_or_serial_out_a, bit8_or_serial_out_b;
  logic [15:0] ea, eb, oes, word;
  int          err_total, num_checks, cyc, wA, wB;
  // Enables and assembled bus word as the host sees them
  assign oes  = {12'h000, parBusUpperOe, parBusLowerOe, bit7Oe, bit8Oe};
  assign word = {par_bus_upper, bit8_or_serial_out_b,
                 bit7_or_serial_out_a, par_bus_lower};
  adc_output_pin_mux adc_output_pin_mux_inst (.core_clk, .reset_n, .clkEn,
    .interface_select, .chipSelect_n, .readOrSclk_n, .oversample_ratio_sel,
    .oversampleRatio, .resultLoad, .resultA, .resultB, .par_bus_upper,
    .parBusUpperOe, .par_bus_lower, .parBusLowerOe, .bit7_or_serial_out_a,
    .bit7Oe, .bit8_or_serial_out_b, .bit8Oe);
  host_model host_model_inst (.core_clk, .interface_select, .chipSelect_n,
    .readOrSclk_n);
  // Reference model: two's complement result widened by sign copies
  function automatic logic [15:0] ext(input int r);
    return 16'(r < 32'h0000_2000 ? r : r + 32'h0000_C000);
  endfunction : ext
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task automatic results();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // Cut a hang short well past the expected run length
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 2000) begin
      err_total++;
      results();
    end
  end
  initial begin
    reset_n = 1'b0; clkEn = 1'b1; resultLoad = 1'b0; resultA = 14'h0000;
    resultB = 14'h0000; oversample_ratio_sel = 3'h0;
    void'($urandom(32'h2544_0f27));
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    @(negedge core_clk);
    chk(oes, 16'h0000);
    // Clock enable low: neither ratio nor result may be taken
    @(posedge core_clk);
    clkEn <= 1'b0;
    oversample_ratio_sel <= 3'h5;
    resultA <= 14'h1FFF;
    resultLoad <= 1'b1;
    host_model_inst.drive(1'b0, 1'b0, 1'b0);
    @(negedge core_clk);
    chk(word, 16'h0000);
    chk({13'h0000, oversampleRatio}, 16'h0000);
    host_model_inst.drive(1'b0, 1'b1, 1'b1);
    clkEn <= 1'b1;
    resultLoad <= 1'b0;
    repeat (8) begin
      wA = $urandom_range(16383);
      wB = $urandom_range(16383);
      ea = ext(wA);
      eb = ext(wB);
      @(posedge core_clk);
      resultA <= wA[13:0];
      resultB <= wB[13:0];
      resultLoad <= 1'b1;
      oversample_ratio_sel <= wB[2:0];
      @(posedge core_clk);
      resultLoad <= 1'b0;
      @(negedge core_clk);
      chk({13'h0000, oversampleRatio}, {13'h0000, wB[2:0]});
      // Any strobe high keeps the whole bus released
      for (int k = 1; k < 4; k++) begin
        host_model_inst.drive(1'b0, k[1], k[0]);
        @(negedge core_clk);
        chk(oes, 16'h0000);
      end
      host_model_inst.drive(1'b0, 1'b0, 1'b0);
      @(negedge core_clk);
      chk(oes, 16'h000F);
      chk(word, ea);
      // Serial frame: chip-select fall gives bit 15, each clock rise the next
      host_model_inst.drive(1'b1, 1'b1, 1'b0);
      host_model_inst.drive(1'b1, 1'b0, 1'b0);
      @(posedge core_clk);
      @(negedge core_clk);
      chk(oes, 16'h0003);
      chk({2'h0, par_bus_upper, par_bus_lower}, 16'h0000);
      for (int i = 15; i >= 0; i--) begin
        if (i < 15) begin
          host_model_inst.drive(1'b1, 1'b0, 1'b1);
          host_model_inst.drive(1'b1, 1'b0, 1'b0);
          @(negedge core_clk);
        end
        chk({14'h0000, bit7_or_serial_out_a, bit8_or_serial_out_b},
            {14'h0000, ea[i], eb[i]});
      end
      host_model_inst.drive(1'b0, 1'b1, 1'b1);
    end
    results();
  end
endmodule : tb
